// [ists_asserts.sv]
// concurrent checks on the slave-transmitter ports
`include "ists_regs.svh"
module ists_asserts (
  input wire logic       i_clk,
  input wire logic       i_rstn,
  input wire logic       i_scl,
  input wire logic       i_serial_buffer_wr,
  input wire logic [7:0] i_serial_buffer_wdata,
  input wire logic       i_serial_control_wr,
  input wire logic [7:0] i_serial_control_wdata,
  input wire logic       i_serial_byte_flag_clr,
  input wire logic       o_scl_oe,
  input wire logic       o_sda_oe,
  input wire logic [7:0] o_serial_buffer,
  input wire logic [7:0] o_serial_status,
  input wire logic [7:0] o_serial_control,
  input wire logic       o_serial_byte_flag
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  wire rel = i_serial_control_wr
             & i_serial_control_wdata[`ISTS_CTRL_RELEASE_BIT];
  chk_flag_stays:
  assert property (o_serial_byte_flag & !i_serial_byte_flag_clr
    |=> o_serial_byte_flag) else $error("flag lost");
  chk_flag_clear:
  assert property ($fell(o_serial_byte_flag) |-> $past(i_serial_byte_flag_clr))
    else $error("flag cleared alone");
  chk_release_scl:
  assert property (rel |=> !o_scl_oe) else $error("scl not freed");
  chk_buffer_load:
  assert property (i_serial_buffer_wr
    |=> o_serial_buffer == $past(i_serial_buffer_wdata)) else $error("buffer");
  chk_hold_scl:
  assert property (o_scl_oe & !rel |=> o_scl_oe) else $error("hold lost");
  chk_hold_flag:
  assert property ($rose(o_scl_oe) |-> o_serial_byte_flag
    & !o_serial_control[`ISTS_CTRL_RELEASE_BIT])
    else $error("hold without flag");
  chk_sda_steady:
  assert property ($changed(o_sda_oe) |-> !$past(i_scl))
    else $error("sda moved while scl high");
  chk_read_match:
  assert property ($rose(o_serial_status[`ISTS_STAT_RW_BIT])
    |-> ##[0:2] o_serial_buffer[0])
    else $error("address not in buffer");
endmodule
////////////////////////////////////////
bind ists_slave_tx ists_asserts ists_asserts_inst (.*);

// [ists_master.sv]
// bus master model: 125 ns bit slots, waits out clock stretching
module ists_master (
  input  wire logic i_scl,
  input  wire logic i_sda,
  output logic      o_scl_oe = 1'b0,
  output logic      o_sda_oe = 1'b0
);
  timeunit 1ns;
  timeprecision 100ps;
  task automatic start_bit();
    o_sda_oe = 1'b1;
    #62.5;
  endtask
  // released sda reads back whatever the slave drives
  task automatic frame9(input logic [8:0] d, output logic [8:0] q);
    for (int i = 8; i >= 0; i--)
    begin
      o_scl_oe = 1'b1;
      #20 o_sda_oe = !d[i];
      #42.5 o_scl_oe = 1'b0;
      wait (i_scl);
      #5 q[i] = i_sda;
      #57.5;
    end
  endtask
  task automatic stop_bit();
    o_scl_oe = 1'b1;
    #20 o_sda_oe = 1'b1;
    #42.5 o_scl_oe = 1'b0;
    #62.5 o_sda_oe = 1'b0;
    #62.5;
  endtask
endmodule

// [ists_pkg.sv]
// types for the two-wire slave-transmitter path
package ists_pkg;
  typedef enum logic [2:0] {
    ISTS_IDLE,
    ISTS_ADDR,
    ISTS_ADDR_ACK,
    ISTS_HOLD,
    ISTS_DATA,
    ISTS_MACK,
    ISTS_SKIP
  } ists_state_t;

  typedef struct packed {
    logic scl_rise;
    logic scl_fall;
    logic scl_lvl;
    logic sda_lvl;
    logic start;
    logic stop;
  } ists_bus_t;
endpackage

// [ists_regs.svh]
// constants for the two-wire slave-transmitter path
// Overview of operation
// - on read-address match, set the read/write status bit.
// - on read-address match, put the address byte in the serial buffer.
// - acknowledge the matched read address in the ninth bit slot.
// - after that acknowledge, clear clock release and hold clock low.
// - writing the serial buffer also loads the shift register.
// - setting clock release (control bit 4) frees the clock line.
// - shift eight bits out: first bit with the release, the rest changing on clock falling edges.
// - raise the byte flag once per byte, address byte included.
// - set the byte flag on the falling edge of the ninth clock.
// - byte flag stays set until software clears it.
// - sample master acknowledge at the ninth clock rising edge.
// - no acknowledge ends the read transfer, stop transmitting.
// - on no acknowledge reset slave logic and status, await a start.
// - on acknowledge, software loads the next byte and sets release.
`ifndef ISTS_REGS_SVH
`define ISTS_REGS_SVH
`define ISTS_CTRL_RELEASE_BIT 4
`define ISTS_STAT_RW_BIT      2
`define ISTS_STAT_RESET       8'h00
`define ISTS_BUF_RESET        8'h00
`define ISTS_CTRL_RESET       8'h00
`define ISTS_SHREG_RESET      8'h00
`define ISTS_CNT_RESET        4'h0
`define ISTS_BITS_PER_BYTE    4'h8
`endif

// [ists_slave_tx.sv]
// two-wire slave-transmitter: address match, ack, clock stretch, shift out
`include "ists_regs.svh"
module ists_slave_tx
  import ists_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_rstn,
  input  wire logic       i_scl,
  input  wire logic       i_sda,
  output wire logic       o_scl_out,
  output wire logic       o_scl_oe,
  output wire logic       o_sda_out,
  output wire logic       o_sda_oe,
  input  wire logic [6:0] i_slave_addr,
  input  wire logic       i_serial_buffer_wr,
  input  wire logic [7:0] i_serial_buffer_wdata,
  input  wire logic       i_serial_control_wr,
  input  wire logic [7:0] i_serial_control_wdata,
  input  wire logic       i_serial_byte_flag_clr,
  output wire logic [7:0] o_serial_buffer,
  output wire logic [7:0] o_serial_status,
  output wire logic [7:0] o_serial_control,
  output wire logic       o_serial_byte_flag,
  output wire logic       o_master_nack
);
  import ists_pkg::*;

  ////////////////////////////////////////
  // all block state in one word: reset and update stay in step
  typedef struct packed {
    ists_state_t st;
    logic [7:0]  shreg;
    logic [7:0]  buffer;
    logic [7:0]  status;
    logic [7:0]  control;
    logic [3:0]  bitcnt;
    logic        flag;
    logic        nack;
    logic        sda_drv;
  } ists_st_t;

  ists_st_t  s_r;
  ists_st_t  s_nxt;
  ists_bus_t bus;

  localparam ists_st_t RESET_ST = '{
    st:      ISTS_IDLE,
    shreg:   `ISTS_SHREG_RESET,
    buffer:  `ISTS_BUF_RESET,
    status:  `ISTS_STAT_RESET,
    control: `ISTS_CTRL_RESET,
    bitcnt:  `ISTS_CNT_RESET,
    flag:    1'b0,
    nack:    1'b0,
    sda_drv: 1'b0
  };

  ////////////////////////////////////////
  // pins reach the state machine two cycles late, and a clock phase
  // shorter than one core cycle can fall between samples and be missed
  ists_sync u_sync (
    .i_clk  (i_clk),
    .i_rstn (i_rstn),
    .i_scl  (i_scl),
    .i_sda  (i_sda),
    .o_bus  (bus)
  );

  ////////////////////////////////////////
  // seven-bit address in [7:1], read/write flag in [0]
  function automatic logic read_match(input logic [7:0] b,
                                      input logic [6:0] a);
    read_match = (b[7:1] == a) && b[0];
  endfunction

  function automatic logic release_set(input logic [7:0] c);
    release_set = c[`ISTS_CTRL_RELEASE_BIT];
  endfunction

  ////////////////////////////////////////
  always_comb
  begin
    s_nxt = s_r;
    if (i_serial_control_wr)
      s_nxt.control = i_serial_control_wdata;
    if (i_serial_buffer_wr)
    begin
      s_nxt.buffer = i_serial_buffer_wdata;
      s_nxt.shreg  = i_serial_buffer_wdata;
    end
    if (i_serial_byte_flag_clr)
      s_nxt.flag = 1'b0;

    if (bus.stop)
    begin
      s_nxt.st      = ISTS_IDLE;
      s_nxt.sda_drv = 1'b0;
    end
    else if (bus.start)
    begin
      s_nxt.st      = ISTS_ADDR;
      s_nxt.bitcnt  = 4'h0;
      s_nxt.sda_drv = 1'b0;
      s_nxt.nack    = 1'b0;
    end
    else
    begin
      unique case (s_r.st)
        ISTS_IDLE: ;
        ISTS_ADDR:
        begin
          if (bus.scl_rise)
          begin
            s_nxt.shreg  = {s_r.shreg[6:0], bus.sda_lvl};
            s_nxt.bitcnt = s_r.bitcnt + 4'h1;
          end
          else if (bus.scl_fall && s_r.bitcnt == `ISTS_BITS_PER_BYTE)
          begin
            // only read requests are served by this path
            if (read_match(s_r.shreg, i_slave_addr))
            begin
              s_nxt.status[`ISTS_STAT_RW_BIT] = 1'b1;
              s_nxt.buffer  = s_r.shreg;
              s_nxt.sda_drv = 1'b1;
              s_nxt.st      = ISTS_ADDR_ACK;
            end
            else
              s_nxt.st = ISTS_SKIP;
          end
        end
        ISTS_ADDR_ACK:
        begin
          if (bus.scl_fall)
          begin
            s_nxt.sda_drv = 1'b0;
            s_nxt.flag    = 1'b1;
            s_nxt.control[`ISTS_CTRL_RELEASE_BIT] = 1'b0;
            s_nxt.st      = ISTS_HOLD;
          end
        end
        ISTS_HOLD:
        begin
          // clock is held low here until software sets release; the
          // write itself is looked at so the line frees on the same edge that loads control
          if (release_set(s_nxt.control))
          begin
            // first bit leaves with the release: no setup before the rise,
            // the master samples well after it sees the line high
            s_nxt.sda_drv = ~s_nxt.shreg[7];
            s_nxt.bitcnt  = 4'h1;
            s_nxt.st      = ISTS_DATA;
          end
        end
        ISTS_DATA:
        begin
          if (bus.scl_fall)
          begin
            if (s_r.bitcnt == `ISTS_BITS_PER_BYTE)
            begin
              s_nxt.sda_drv = 1'b0;
              s_nxt.st      = ISTS_MACK;
            end
            else
            begin
              s_nxt.shreg   = {s_r.shreg[6:0], 1'b0};
              s_nxt.sda_drv = ~s_r.shreg[6];
              s_nxt.bitcnt  = s_r.bitcnt + 4'h1;
            end
          end
        end
        ISTS_MACK:
        begin
          if (bus.scl_rise)
            s_nxt.nack = bus.sda_lvl;
          else if (bus.scl_fall)
          begin
            s_nxt.flag = 1'b1;
            if (s_r.nack)
            begin
              s_nxt.status = `ISTS_STAT_RESET;
              s_nxt.st     = ISTS_IDLE;
            end
            else
            begin
              s_nxt.control[`ISTS_CTRL_RELEASE_BIT] = 1'b0;
              s_nxt.st = ISTS_HOLD;
            end
          end
        end
        // not ours: sit out until the next start or stop
        ISTS_SKIP: ;
        // an unused state code falls back to idle with the bus released
        default:
        begin
          s_nxt.st      = ISTS_IDLE;
          s_nxt.sda_drv = 1'b0;
        end
      endcase
    end
    // hardware set wins over a software clear in the same cycle
    if (i_serial_byte_flag_clr && s_r.flag && s_nxt.flag
        && !(s_r.st != s_nxt.st))
      s_nxt.flag = 1'b0;
  end

  ////////////////////////////////////////
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
      s_r <= RESET_ST;
    else
      s_r <= s_nxt;
  end

  ////////////////////////////////////////
  // open drain: only ever pull low
  assign o_scl_out          = 1'b0;
  assign o_scl_oe           = (s_r.st == ISTS_HOLD);
  assign o_sda_out          = 1'b0;
  assign o_sda_oe           = s_r.sda_drv;
  assign o_serial_buffer    = s_r.buffer;
  assign o_serial_status    = s_r.status;
  assign o_serial_control   = s_r.control;
  assign o_serial_byte_flag = s_r.flag;
  assign o_master_nack      = s_r.nack;
endmodule

// [ists_slave_tx_bench.sv]
// bench: master model on the wire, software side driven from here
module ists_slave_tx_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic       i_clk = 1'b0, i_rstn = 1'b0, flag, nack;
  logic [2:0] wr = 3'b000;
  logic [7:0] wdata = 8'h00, buf_q, stat_q, ctrl_q;
  logic [6:0] addr = 7'h00;
  logic       m_scl, m_sda, s_scl, s_sda, scl_o, sda_o;
  int         num_errors = 0, checks_done = 0, cyc = 0;
  // open-drain lines: pulled up unless either side pulls low
  wire        scl = !m_scl & (s_scl ? scl_o : 1'b1);
  wire        sda = !m_sda & (s_sda ? sda_o : 1'b1);
  always #5 i_clk = ~i_clk;
  ists_master ists_master_inst (.i_scl(scl), .i_sda(sda), .o_scl_oe(m_scl),
    .o_sda_oe(m_sda));
  ists_slave_tx ists_slave_tx_inst (.i_clk(i_clk), .i_rstn(i_rstn),
    .i_scl(scl), .i_sda(sda), .o_scl_out(scl_o), .o_scl_oe(s_scl),
    .o_sda_out(sda_o), .o_sda_oe(s_sda), .i_slave_addr(addr),
    .i_serial_buffer_wr(wr[1]),
    .i_serial_buffer_wdata(wdata), .i_serial_control_wr(wr[0]),
    .i_serial_control_wdata(wdata), .i_serial_byte_flag_clr(wr[2]),
    .o_serial_buffer(buf_q), .o_serial_status(stat_q),
    .o_serial_control(ctrl_q), .o_serial_byte_flag(flag),
    .o_master_nack(nack));
  task automatic check(input logic [9:0] got, input logic [9:0] exp);
    checks_done++;
    if (got !== exp)
      $display("BAD %0t got %h exp %h", $time, got, exp);
    if (got !== exp)
      num_errors++;
  endtask
  // k picks the strobe: 0 flag clear, 1 buffer, 2 control
  task automatic pulse(input int k, input logic [7:0] d);
    @(negedge i_clk);
    wdata = d;
    wr = 3'b100 >> k;
    @(negedge i_clk);
    wr = 3'b000;
  endtask
  task automatic complete_run();
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge i_clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      num_errors++;
      complete_run();
    end
  end
  ////////////////////////////////////////
  initial
  begin
    logic [8:0] q;
    logic [7:0] d[$];
    int n;
    void'($urandom(94));
    repeat (5) @(negedge i_clk);
    i_rstn = 1'b1;
    repeat (2) @(negedge i_clk);
    addr = 7'($urandom);
    n = 2 + $urandom % 3;
    repeat (n) d.push_back(8'($urandom));
    // a write to us and a read to another address must both be ignored
    for (int k = 0; k < 2; k++)
    begin
      ists_master_inst.start_bit();
      ists_master_inst.frame9({addr ^ 7'(k), 1'(k), 1'b1}, q);
      check({q[0], flag}, 2'b10);
      ists_master_inst.stop_bit();
    end
    fork
      begin
        ists_master_inst.start_bit();
        ists_master_inst.frame9({addr, 2'b11}, q);
        check(q[0], 1'b0);
        for (int i = 0; i < n; i++)
        begin
          ists_master_inst.frame9({8'hff, i == n - 1}, q);
          check(q[8:1], d[i]);
        end
        ists_master_inst.stop_bit();
      end
      for (int i = 0; i < n; i++)
      begin
        wait (flag);
        repeat (4) @(negedge i_clk);
        if (i == 0) check({stat_q[2], buf_q}, {1'b1, addr, 1'b1});
        check({s_scl, ctrl_q[4]}, 2'b10);
        pulse(0, 8'h00);
        pulse(1, d[i]);
        pulse(2, 8'h10);
      end
    join
    check({flag, nack, stat_q}, {2'b11, 8'h00});
    complete_run();
  end
endmodule

// [ists_sync.sv]
// pin synchronisers and edge / start / stop detection
module ists_sync
  import ists_pkg::*;
(
  input  wire logic      i_clk,
  input  wire logic      i_rstn,
  input  wire logic      i_scl,
  input  wire logic      i_sda,
  output ists_pkg::ists_bus_t o_bus
);
  typedef struct packed {
    logic [1:0] scl_m;
    logic [1:0] sda_m;
    logic       scl_q;
    logic       sda_q;
  } ists_sync_st_t;

  ists_sync_st_t s_r;
  ists_sync_st_t s_nxt;

  always_comb
  begin
    s_nxt       = s_r;
    s_nxt.scl_m = {s_r.scl_m[0], i_scl};
    s_nxt.sda_m = {s_r.sda_m[0], i_sda};
    s_nxt.scl_q = s_r.scl_m[1];
    s_nxt.sda_q = s_r.sda_m[1];
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
      s_r <= '{scl_m: 2'h3, sda_m: 2'h3, scl_q: 1'b1, sda_q: 1'b1};
    else
      s_r <= s_nxt;
  end

  // only stage [1] of each synchroniser is read here
  assign o_bus.scl_rise = s_r.scl_m[1] & ~s_r.scl_q;
  assign o_bus.scl_fall = ~s_r.scl_m[1] & s_r.scl_q;
  assign o_bus.scl_lvl  = s_r.scl_m[1];
  assign o_bus.sda_lvl  = s_r.sda_m[1];
  assign o_bus.start    = s_r.scl_m[1] & s_r.scl_q & s_r.sda_q
                          & ~s_r.sda_m[1];
  assign o_bus.stop     = s_r.scl_m[1] & s_r.scl_q & ~s_r.sda_q
                          & s_r.sda_m[1];
endmodule
